/* pdc_channel.sv */
// The implementer's own choices: the address map and the plain strobed port.
module pdc_channel
    import pdc_pkg::*;
#(
    parameter int SEMA_W = 8
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    output logic             mem_req_out,
    output logic             mem_we_out,
    output logic      [31:0] mem_addr_out,
    output logic      [31:0] mem_wdata_out,
    input  wire logic        mem_ready_in,
    input  wire logic [31:0] mem_rdata_in,
    output logic             per_req_out,
    output logic             per_we_out,
    output logic      [31:0] per_addr_out,
    output logic      [31:0] per_wdata_out,
    input  wire logic        per_ready_in,
    input  wire logic [31:0] per_rdata_in,
    input  wire logic        per_end_cmd_in,
    output logic             irq_out
);
    import pdc_pkg::*;

    pdc_state_type     state;
    logic [31:0]       next_command_pointer;
    logic [31:0]       channel_current_command;
    logic [31:0]       buf_addr;
    logic [31:0]       data_word;
    logic [1:0]        fetch_idx;
    logic [3:0]        pio_idx;
    logic [16:0]       rem_bytes;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic [STAT_W-1:0] evt;
    logic [SEMA_W-1:0] sema_count;
    logic              sema_next_zero;
    logic              sema_inc;
    logic              sema_dec;
    logic              start_req;
    pdc_op_type        op;
    logic [3:0]        pio_word_count;
    logic [15:0]       byte_count;
    logic              wait_peripheral_done;
    logic              sema_en;
    logic              irq_on_finish;
    logic              chain;

    assign op                   = pdc_op_type'(channel_current_command[CMD_TYPE_MSB:CMD_TYPE_LSB]);
    assign pio_word_count       = channel_current_command[CMD_PIO_MSB:CMD_PIO_LSB];
    assign byte_count           = channel_current_command[CMD_COUNT_MSB:CMD_COUNT_LSB];
    assign wait_peripheral_done = channel_current_command[CMD_WAIT_BIT];
    assign sema_en              = channel_current_command[CMD_SEMA_BIT];
    assign irq_on_finish        = channel_current_command[CMD_IRQ_BIT];
    assign chain                = channel_current_command[CMD_CHAIN_BIT];

    assign start_req = reg_wr_in && reg_addr_in == REG_CTRL_ADDR && reg_wdata_in[CTRL_START_BIT];
    assign sema_inc  = reg_wr_in && reg_addr_in == REG_SEMA_ADDR;
    assign sema_dec  = state == ST_FINISH && sema_en;

    pdc_semaphore #(
        .SEMA_W (SEMA_W)
    ) u_sema (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .inc_in        (sema_inc),
        .inc_amount_in (reg_wdata_in[SEMA_W-1:0]),
        .dec_in        (sema_dec),
        .count_out     (sema_count),
        .next_zero_out (sema_next_zero)
    );

    // handshake outputs follow the state directly
    assign mem_req_out = state == ST_FETCH || state == ST_PIO_RD
                      || (state == ST_XFER_SRC && op == OP_M2P)
                      || (state == ST_XFER_DST && op == OP_P2M);
    assign mem_we_out  = state == ST_XFER_DST;
    assign per_req_out = state == ST_PIO_WR
                      || (state == ST_XFER_SRC && op == OP_P2M)
                      || (state == ST_XFER_DST && op == OP_M2P);
    assign per_we_out  = state != ST_XFER_SRC;
    assign mem_wdata_out = data_word;
    assign per_wdata_out = data_word;

    // data phase entry shared by the fetch and pio paths
    function automatic pdc_state_type after_pio(input pdc_op_type o);
        if (o == OP_P2M || o == OP_M2P) begin
            after_pio = ST_XFER_SRC;
        end else begin
            after_pio = ST_WAIT_END;
        end
    endfunction

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state                   <= ST_IDLE;
            fetch_idx               <= '0;
            pio_idx                 <= '0;
            rem_bytes               <= '0;
            mem_addr_out            <= '0;
            per_addr_out            <= '0;
            data_word               <= '0;
            buf_addr                <= '0;
            channel_current_command <= '0;
            next_command_pointer    <= '0;
        end else begin
            if (reg_wr_in && reg_addr_in == REG_NEXT_PTR_ADDR && state == ST_IDLE) begin
                next_command_pointer <= reg_wdata_in;
            end
            case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        state        <= ST_FETCH;
                        fetch_idx    <= DESC_NEXT_IDX;
                        mem_addr_out <= next_command_pointer;
                    end
                end
                ST_FETCH: begin
                    if (mem_ready_in) begin
                        mem_addr_out <= mem_addr_out + WORD_BYTES;
                        fetch_idx    <= fetch_idx + 2'h1;
                        if (fetch_idx == DESC_NEXT_IDX) begin
                            next_command_pointer <= mem_rdata_in;
                        end else if (fetch_idx == DESC_CMD_IDX) begin
                            channel_current_command <= mem_rdata_in & CMD_VALID_MASK;
                        end else begin
                            buf_addr <= mem_rdata_in;
                            pio_idx  <= '0;
                            per_addr_out <= PERIPH_BASE_PIO_ADDR;
                            // zero count means 64 kbytes
                            rem_bytes <= (byte_count == '0) ? FULL_COUNT_BYTES : {1'b0, byte_count};
                            if (pio_word_count != '0) begin
                                state <= ST_PIO_RD;
                            end else begin
                                state <= after_pio(op);
                                per_addr_out <= PERIPH_DATA_ADDR;
                                mem_addr_out <= mem_rdata_in;
                            end
                        end
                    end
                end
                ST_PIO_RD: begin
                    if (mem_ready_in) begin
                        data_word <= mem_rdata_in;
                        state     <= ST_PIO_WR;
                    end
                end
                ST_PIO_WR: begin
                    if (per_ready_in) begin
                        pio_idx <= pio_idx + 4'h1;
                        if (pio_idx + 4'h1 == pio_word_count) begin
                            state        <= after_pio(op);
                            per_addr_out <= PERIPH_DATA_ADDR;
                            mem_addr_out <= buf_addr;
                        end else begin
                            state        <= ST_PIO_RD;
                            mem_addr_out <= mem_addr_out + WORD_BYTES;
                            per_addr_out <= per_addr_out + WORD_BYTES;
                        end
                    end
                end
                ST_XFER_SRC: begin
                    if ((op == OP_P2M && per_ready_in) || (op == OP_M2P && mem_ready_in)) begin
                        data_word <= (op == OP_P2M) ? per_rdata_in : mem_rdata_in;
                        state     <= ST_XFER_DST;
                    end
                end
                ST_XFER_DST: begin
                    if ((op == OP_P2M && mem_ready_in) || (op == OP_M2P && per_ready_in)) begin
                        mem_addr_out <= mem_addr_out + WORD_BYTES;
                        // a last partial word still moves as a whole word
                        if (rem_bytes <= WORD_COUNT_BYTES) begin
                            rem_bytes <= '0;
                            state     <= ST_WAIT_END;
                        end else begin
                            rem_bytes <= rem_bytes - WORD_COUNT_BYTES;
                            state     <= ST_XFER_SRC;
                        end
                    end
                end
                ST_WAIT_END: begin
                    if (!wait_peripheral_done || per_end_cmd_in) begin
                        state <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    if (sema_en && sema_next_zero) begin
                        state <= ST_STALL;
                    end else if (chain) begin
                        state        <= ST_FETCH;
                        fetch_idx    <= DESC_NEXT_IDX;
                        mem_addr_out <= next_command_pointer;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_STALL: begin
                    if (sema_count != '0) begin
                        if (chain) begin
                            state        <= ST_FETCH;
                            fetch_idx    <= DESC_NEXT_IDX;
                            mem_addr_out <= next_command_pointer;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // sticky status, set wins over a same-cycle clear
    assign evt[STAT_DONE_BIT] = state == ST_FINISH && irq_on_finish;
    assign evt[STAT_BAD_BIT]  = state == ST_FINISH && op == OP_RSVD;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status <= '0;
        end else if (reg_wr_in && reg_addr_in == REG_STATUS_ADDR) begin
            status <= (status & ~reg_wdata_in[STAT_W-1:0]) | evt;
        end else begin
            status <= status | evt;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask <= '0;
        end else if (reg_wr_in && reg_addr_in == REG_MASK_ADDR) begin
            mask <= reg_wdata_in[STAT_W-1:0];
        end
    end

    assign irq_out = |(status & mask);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= '0;
        end else if (reg_addr_in == REG_CTRL_ADDR) begin
            reg_rdata_out <= 32'(state != ST_IDLE) << CTRL_BUSY_BIT;
        end else if (reg_addr_in == REG_NEXT_PTR_ADDR) begin
            reg_rdata_out <= next_command_pointer;
        end else if (reg_addr_in == REG_CUR_CMD_ADDR) begin
            reg_rdata_out <= channel_current_command;
        end else if (reg_addr_in == REG_SEMA_ADDR) begin
            reg_rdata_out <= 32'(sema_count);
        end else if (reg_addr_in == REG_STATUS_ADDR) begin
            reg_rdata_out <= 32'(status);
        end else if (reg_addr_in == REG_MASK_ADDR) begin
            reg_rdata_out <= 32'(mask);
        end else if (reg_addr_in == REG_BUF_ADDR_ADDR) begin
            reg_rdata_out <= buf_addr;
        end else begin
            reg_rdata_out <= '0;
        end
    end

    // checks
    a_wait_end_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_WAIT_END && wait_peripheral_done && !per_end_cmd_in |=> state == ST_WAIT_END)
        else $error("left wait before peripheral end");

    a_sema_dec_one: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_FINISH && sema_en && !sema_inc && sema_count != '0
        |=> sema_count == $past(sema_count) - 1'b1)
        else $error("semaphore not decremented");

    a_stall_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_STALL && sema_count == '0 && !sema_inc |=> state == ST_STALL)
        else $error("stall left with zero semaphore");

    a_irq_status_set: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_FINISH && irq_on_finish |=> status[STAT_DONE_BIT] && (!mask[STAT_DONE_BIT] || irq_out))
        else $error("completion status not set");

    a_chain_fetch: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_FINISH && chain && !(sema_en && sema_next_zero)
        |=> state == ST_FETCH && mem_addr_out == next_command_pointer && mem_req_out && !mem_we_out)
        else $error("chain did not fetch next descriptor");

    a_pio_only_nodata: assert property (@(posedge clk_in) disable iff (rst_in)
        (op == OP_PIO_ONLY || op == OP_RSVD) |-> !(state == ST_XFER_SRC || state == ST_XFER_DST))
        else $error("data moved for non-transfer command");

    a_p2m_direction: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_XFER_SRC && op == OP_P2M |-> per_req_out && !per_we_out && !mem_req_out
        && per_addr_out == PERIPH_DATA_ADDR)
        else $error("p2m source is not a peripheral read");

    a_m2p_direction: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_XFER_DST && op == OP_M2P |-> per_req_out && per_we_out && !mem_req_out)
        else $error("m2p sink is not a peripheral write");

    a_zero_count_full: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_FETCH && fetch_idx == DESC_BUF_IDX && mem_ready_in && byte_count == '0
        |=> rem_bytes == FULL_COUNT_BYTES)
        else $error("zero byte count not taken as 64k");

    a_pio_first: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_FETCH && fetch_idx == DESC_BUF_IDX && mem_ready_in && pio_word_count != '0
        |=> state == ST_PIO_RD ##1 (state == ST_PIO_RD || state == ST_PIO_WR))
        else $error("pio words not sent first");

    a_idle_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_IDLE && !start_req |=> state == ST_IDLE && !mem_req_out && !per_req_out)
        else $error("idle channel moved without restart");

    a_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        (channel_current_command & ~CMD_VALID_MASK) == '0)
        else $error("reserved command bits set");

    c_chain_taken: cover property (@(posedge clk_in) disable iff (rst_in)
        state == ST_FINISH && chain ##1 state == ST_FETCH);
    c_stall_resume: cover property (@(posedge clk_in) disable iff (rst_in)
        state == ST_STALL ##1 state != ST_STALL);
    c_p2m_word: cover property (@(posedge clk_in) disable iff (rst_in)
        state == ST_XFER_DST && op == OP_P2M && mem_ready_in);
    c_wait_end: cover property (@(posedge clk_in) disable iff (rst_in)
        state == ST_WAIT_END && wait_peripheral_done && per_end_cmd_in);
endmodule

/* pdc_far_model.sv */
module pdc_far_model
    import pdc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        slow_in,
    input  wire logic        clear_in,
    input  wire logic        mem_req_in,
    input  wire logic        mem_we_in,
    input  wire logic [31:0] mem_addr_in,
    input  wire logic [31:0] mem_wdata_in,
    output logic             mem_ready_out,
    output logic      [31:0] mem_rdata_out,
    input  wire logic        per_req_in,
    input  wire logic        per_we_in,
    input  wire logic [31:0] per_addr_in,
    input  wire logic [31:0] per_wdata_in,
    output logic             per_ready_out,
    output logic      [31:0] per_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:1023];
    logic        tick = 1'b0;
    logic        order_bad = 1'b0;
    int          pio_n = 0;
    int          dat_n = 0;
    int          memwr_n = 0;
    int          memreq_n = 0;
    // slow mode answers every other cycle, memory and peripheral out of step
    assign mem_ready_out = mem_req_in & (~slow_in | tick);
    assign per_ready_out = per_req_in & (~slow_in | ~tick);
    // lines not answering carry inverted data so a stale value never looks valid
    assign mem_rdata_out = mem_ready_out ? mem[mem_addr_in[11:2]] : ~mem[mem_addr_in[11:2]];
    assign per_rdata_out = per_ready_out ? 32'hd000_0000 + 32'(dat_n) : 32'h2fff_ffff - 32'(dat_n);
    always @(posedge clk_in) begin
        tick <= ~tick;
        if (clear_in) begin
            pio_n <= 0;
            dat_n <= 0;
            memwr_n <= 0;
            order_bad <= 1'b0;
        end else begin
            if (mem_ready_out) begin
                memreq_n <= memreq_n + 1;
                if (mem_we_in) begin
                    mem[mem_addr_in[11:2]] <= mem_wdata_in;
                    memwr_n <= memwr_n + 1;
                end
            end
            if (per_ready_out && per_addr_in == PERIPH_DATA_ADDR) begin
                dat_n <= dat_n + 1;
            end else if (per_ready_out) begin
                // pio words first, rising addresses, words in descriptor order
                if (dat_n != 0 || !per_we_in || per_addr_in != PERIPH_BASE_PIO_ADDR + 32'(4 * pio_n)
                    || per_wdata_in != 32'ha000_0000 + 32'(pio_n)) begin
                    order_bad <= 1'b1;
                end
                pio_n <= pio_n + 1;
            end
        end
    end
endmodule

/* pdc_pkg.sv */
package pdc_pkg;

    // register map of the channel, word aligned byte addresses
    localparam logic [7:0] REG_CTRL_ADDR      = 8'h00;
    localparam logic [7:0] REG_NEXT_PTR_ADDR  = 8'h04;
    localparam logic [7:0] REG_CUR_CMD_ADDR   = 8'h08;
    localparam logic [7:0] REG_SEMA_ADDR      = 8'h0c;
    localparam logic [7:0] REG_STATUS_ADDR    = 8'h10;
    localparam logic [7:0] REG_MASK_ADDR      = 8'h14;
    localparam logic [7:0] REG_BUF_ADDR_ADDR  = 8'h18;

    // control and status fields
    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_BUSY_BIT    = 1;
    localparam int STAT_DONE_BIT    = 0;
    localparam int STAT_BAD_BIT     = 1;
    localparam int STAT_W           = 2;

    // channel_current_command fields
    localparam int CMD_COUNT_LSB    = 16;
    localparam int CMD_COUNT_MSB    = 31;
    localparam int CMD_PIO_LSB      = 12;
    localparam int CMD_PIO_MSB      = 15;
    localparam int CMD_WAIT_BIT     = 7;
    localparam int CMD_SEMA_BIT     = 6;
    localparam int CMD_IRQ_BIT      = 3;
    localparam int CMD_CHAIN_BIT    = 2;
    localparam int CMD_TYPE_LSB     = 0;
    localparam int CMD_TYPE_MSB     = 1;
    localparam logic [31:0] CMD_VALID_MASK = 32'hffff_f0cf;

    // descriptor layout in memory, word index
    localparam logic [1:0] DESC_NEXT_IDX = 2'h0;
    localparam logic [1:0] DESC_CMD_IDX  = 2'h1;
    localparam logic [1:0] DESC_BUF_IDX  = 2'h2;
    localparam logic [31:0] DESC_PIO_OFFSET = 32'h0000_000c;
    localparam logic [31:0] WORD_BYTES      = 32'h0000_0004;

    // attached_peripheral register addresses
    localparam logic [31:0] PERIPH_BASE_PIO_ADDR = 32'h0000_0000;
    localparam logic [31:0] PERIPH_DATA_ADDR     = 32'h0000_0010;

    localparam logic [16:0] FULL_COUNT_BYTES = 17'h1_0000;
    localparam logic [16:0] WORD_COUNT_BYTES = 17'h0_0004;

    typedef enum logic [1:0] {
        OP_PIO_ONLY = 2'b00,
        OP_P2M      = 2'b01,
        OP_M2P      = 2'b10,
        OP_RSVD     = 2'b11
    } pdc_op_type;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_FETCH    = 4'b0001,
        ST_PIO_RD   = 4'b0010,
        ST_PIO_WR   = 4'b0011,
        ST_XFER_SRC = 4'b0100,
        ST_XFER_DST = 4'b0101,
        ST_WAIT_END = 4'b0110,
        ST_FINISH   = 4'b0111,
        ST_STALL    = 4'b1000
    } pdc_state_type;

endpackage

module pdc_semaphore #(
    parameter int SEMA_W = 8
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              inc_in,
    input  wire logic [SEMA_W-1:0] inc_amount_in,
    input  wire logic              dec_in,
    output logic      [SEMA_W-1:0] count_out,
    output logic                   next_zero_out
);
    logic [SEMA_W-1:0] count;
    logic [SEMA_W-1:0] next_count;

    generate
        if (SEMA_W < 1 || SEMA_W > 16) begin : g_bad_w
            $error("pdc_semaphore: SEMA_W must be 1..16");
        end
    endgenerate

    // increment and decrement in one cycle both count; no underflow
    always_comb begin
        next_count = count + (inc_in ? inc_amount_in : '0);
        if (dec_in && next_count != '0) begin
            next_count = next_count - 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign count_out     = count;
    assign next_zero_out = (next_count == '0);
endmodule

/* peripheral_dma_channel_command_tb.sv */
module peripheral_dma_channel_command_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pdc_pkg::*;
    typedef struct {
        logic [31:0] cmd;
        int          pio;
        int          dat;
        int          mw;
        logic [31:0] st;
        logic        slow;
    } pdc_row_type;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
    logic [31:0] per_addr_out, per_wdata_out, per_rdata_in;
    logic        mem_req_out, mem_we_out, mem_ready_in, per_req_out, per_we_out, per_ready_in, irq_out;
    logic        per_end_cmd_in = 1'b0;
    logic        slow = 1'b0;
    logic        clear = 1'b0;
    int          failures = 0;
    int          comparisons = 0;
    logic [31:0] d;
    int          snap;
    pdc_row_type rows [5] = '{
        '{32'h0004_2000, 2, 0, 0, 32'h0, 1'b0},      // pio only
        '{32'h0008_0001, 0, 2, 2, 32'h0, 1'b1},      // peripheral to memory, slow
        '{32'h0006_3002, 3, 2, 0, 32'h0, 1'b0},      // memory to peripheral, partial word
        '{32'h0000_1f33, 1, 0, 0, 32'h2, 1'b1},      // reserved type, reserved bits set
        '{32'h0000_0002, 0, 16384, 0, 32'h0, 1'b0}   // zero count is the full size
    };
    always #5 clk_in = ~clk_in;
    pdc_channel uut (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ready_in, .mem_rdata_in, .per_req_out,
        .per_we_out, .per_addr_out, .per_wdata_out, .per_ready_in, .per_rdata_in, .per_end_cmd_in, .irq_out);
    pdc_far_model far (.clk_in(clk_in), .slow_in(slow), .clear_in(clear), .mem_req_in(mem_req_out),
        .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
        .mem_ready_out(mem_ready_in), .mem_rdata_out(mem_rdata_in), .per_req_in(per_req_out),
        .per_we_in(per_we_out), .per_addr_in(per_addr_out), .per_wdata_in(per_wdata_out),
        .per_ready_out(per_ready_in), .per_rdata_out(per_rdata_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask
    task automatic desc(input int p, input logic [31:0] nx, input logic [31:0] c);
        far.mem[p / 4] = nx;
        far.mem[p / 4 + 1] = c;
        far.mem[p / 4 + 2] = 32'h0000_0800;
        for (int i = 0; i < 15; i++) far.mem[p / 4 + 3 + i] = 32'ha000_0000 + 32'(i);
    endtask
    task automatic go(input logic [31:0] p);
        @(posedge clk_in);
        clear <= 1'b1;
        @(posedge clk_in);
        clear <= 1'b0;
        wr(REG_NEXT_PTR_ADDR, p);
        wr(REG_CTRL_ADDR, 32'h1);
    endtask
    task automatic wait_idle;
        logic [31:0] v;
        int          n;
        v = 32'h2;
        n = 0;
        while (v[CTRL_BUSY_BIT] === 1'b1 && n < 40000) begin
            rd(REG_CTRL_ADDR, v);
            n++;
        end
        check(v & 32'h2, 32'h0);
    endtask
    task automatic summarize;
        $display("counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #1_000_000;
        failures++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        check(32'(irq_out), 32'h0);
        wr(REG_CUR_CMD_ADDR, 32'h1234_5678);
        rd(REG_CUR_CMD_ADDR, d);
        check(d, 32'h0);
        rd(8'h1c, d);
        check(d, 32'h0);
        $display("reset test done");
        for (int r = 0; r < 5; r++) begin
            desc(32'h100, 32'h0, rows[r].cmd);
            slow <= rows[r].slow;
            go(32'h100);
            wait_idle();
            check(32'(far.pio_n), 32'(rows[r].pio));
            check(32'(far.dat_n), 32'(rows[r].dat));
            check(32'(far.memwr_n), 32'(rows[r].mw));
            check(32'(far.order_bad), 32'h0);
            rd(REG_CUR_CMD_ADDR, d);
            check(d, rows[r].cmd & CMD_VALID_MASK);
            rd(REG_STATUS_ADDR, d);
            check(d, rows[r].st);
            wr(REG_STATUS_ADDR, 32'h3);
            $display("row %0d done", r);
        end
        // p2m row left the peripheral words in the buffer
        check(far.mem[512], 32'hd000_0000);
        check(far.mem[513], 32'hd000_0001);
        slow <= 1'b0;
        desc(32'h100, 32'h200, 32'h0000_008c);
        desc(32'h200, 32'h0, 32'h0000_1000);
        wr(REG_MASK_ADDR, 32'h1);
        go(32'h100);
        repeat (30) @(posedge clk_in);
        rd(REG_CTRL_ADDR, d);
        check(d & 32'h2, 32'h2);
        rd(REG_CUR_CMD_ADDR, d);
        check(d, 32'h0000_008c);
        @(posedge clk_in);
        per_end_cmd_in <= 1'b1;
        wait_idle();
        @(posedge clk_in);
        per_end_cmd_in <= 1'b0;
        rd(REG_CUR_CMD_ADDR, d);
        check(d, 32'h0000_1000);
        rd(REG_STATUS_ADDR, d);
        check(d, 32'h1);
        check(32'(irq_out), 32'h1);
        wr(REG_MASK_ADDR, 32'h0);
        #1 check(32'(irq_out), 32'h0);
        wr(REG_MASK_ADDR, 32'h1);
        #1 check(32'(irq_out), 32'h1);
        wr(REG_STATUS_ADDR, 32'h1);
        #1 check(32'(irq_out), 32'h0);
        $display("chain test done");
        wr(REG_SEMA_ADDR, 32'h1);
        desc(32'h100, 32'h0, 32'h0000_0040);
        go(32'h100);
        repeat (20) @(posedge clk_in);
        rd(REG_CTRL_ADDR, d);
        check(d & 32'h2, 32'h2);
        rd(REG_SEMA_ADDR, d);
        check(d, 32'h0);
        wr(REG_SEMA_ADDR, 32'h1);
        wait_idle();
        snap = far.memreq_n;
        repeat (20) @(posedge clk_in);
        check(32'(far.memreq_n), 32'(snap));
        $display("semaphore test done");
        summarize();
    end
endmodule
